// ===== design/ldo_pkg.sv
/*
 * ldo_pkg: register map, field positions and reset values for the
 * ldo regulator control register bank.
 * Assumes a 32-bit apb bus where byte address = 4 * register index.
 */
package ldo_pkg;

	// channel count and field widths
	localparam int unsigned NUM_CH = 3;
	localparam int unsigned LEVEL_W = 6;
	localparam int unsigned IDX_W = 8;
	localparam int unsigned ADDR_W = 12;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_CH8_LEVEL = 8'h68;
	localparam logic [7:0] IDX_CH8_CTRL = 8'h69;
	localparam logic [7:0] IDX_CH9_LEVEL = 8'h70;
	localparam logic [7:0] IDX_CH9_CTRL = 8'h71;
	localparam logic [7:0] IDX_CH10_LEVEL = 8'h80;
	localparam logic [7:0] IDX_CH10_CTRL = 8'h81;
	localparam logic [7:0] IDX_IRQ_SRC = 8'hc1;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'hd0;
	localparam logic [7:0] IDX_IRQ_MASK = 8'hd1;

	// per-channel lookup, channel 0 = ch8
	localparam logic [7:0] CH_LEVEL_IDX [NUM_CH] = '{
		IDX_CH8_LEVEL, IDX_CH9_LEVEL, IDX_CH10_LEVEL};
	localparam logic [7:0] CH_CTRL_IDX [NUM_CH] = '{
		IDX_CH8_CTRL, IDX_CH9_CTRL, IDX_CH10_CTRL};

	// control/status register bit positions
	localparam int unsigned BIT_ENABLE = 7;
	localparam int unsigned BIT_DISCHARGE = 2;
	localparam int unsigned BIT_FAULT_IE = 1;
	localparam int unsigned BIT_POWER_GOOD = 0;

	// reset values
	localparam logic [5:0] LEVEL_RST = 6'h00;
	localparam logic [2:0] CTRL_RST = 3'h0;
	localparam logic [2:0] MASK_RST = 3'h0;
	localparam logic [7:0] SRC_IDLE = 8'hff;

endpackage : ldo_pkg

// ===== design/ldo_regs.sv
/*
 * ldo_regs: apb register bank for three ldo channels (ch8, ch9, ch10):
 * output level select, enable, discharge, fault interrupt enable,
 * power-good status, w1c interrupt status, read/write interrupt mask and source address.
 * Assumes power_good and fault come from the analog domain (async),
 * one 10 MHz clock, synchronous active-high reset.
 */
// Register access over APB is this design's own decision.
`timescale 1ns/1ps

// Contract
// - six-bit level field, bits 5:0, read/write
// - control bit 7 switches regulator on/off
// - control bit 2 enables output discharge
// - discharge only when off and enabled
// - control bit 1 gates channel fault interrupts
// - control bit 0 reads power-good status
// - source address byte, 0xff, resets on read
module ldo_regs
	import ldo_pkg::*;
(
	// clock, reset, enable
	input wire logic clock,
	input wire logic reset,
	input wire logic ce,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// analog side, asynchronous
	input wire logic [NUM_CH-1:0] power_good,
	input wire logic [NUM_CH-1:0] fault,
	// regulator controls
	output logic [NUM_CH-1:0] regulator_on,
	output logic [NUM_CH-1:0] discharge_on,
	output logic [LEVEL_W-1:0] level_ch8,
	output logic [LEVEL_W-1:0] level_ch9,
	output logic [LEVEL_W-1:0] level_ch10,
	// interrupt
	output logic irq
);

	// word index of an aligned address, all-ones when misaligned
	function automatic logic [IDX_W-1:0] idx_of(
		input logic [ADDR_W-1:0] a);
		logic [IDX_W-1:0] r;
		r = a[IDX_W+1:2];
		if (a[1:0] != 2'b00 || a[ADDR_W-1:IDX_W+2] != '0)
			r = 8'hff;
		return r;
	endfunction : idx_of

	function automatic logic is_mapped(input logic [IDX_W-1:0] i);
		logic m;
		m = 1'b0;
		for (int c = 0; c < NUM_CH; c++)
			if (i == CH_LEVEL_IDX[c] || i == CH_CTRL_IDX[c])
				m = 1'b1;
		if (i == IDX_IRQ_SRC || i == IDX_IRQ_STATUS || i == IDX_IRQ_MASK)
			m = 1'b1;
		return m;
	endfunction : is_mapped

	// state
	logic [LEVEL_W-1:0] level_r [NUM_CH];
	logic [NUM_CH-1:0] en_r;
	logic [NUM_CH-1:0] discharge_en_r;
	logic [NUM_CH-1:0] fie_r;
	logic [NUM_CH-1:0] irq_status_r;
	logic [NUM_CH-1:0] irq_mask_r;
	logic [7:0] src_r;
	logic [31:0] prdata_r;
	logic pslverr_r;

	// synchronisers
	logic [NUM_CH-1:0] pg_meta_r;
	logic [NUM_CH-1:0] pg_s_r;
	logic [NUM_CH-1:0] flt_meta_r;
	logic [NUM_CH-1:0] flt_s_r;
	logic [NUM_CH-1:0] flt_d_r;

	// bus decode
	logic setup;
	logic access;
	logic wr;
	logic rd;
	logic [IDX_W-1:0] idx;
	logic [NUM_CH-1:0] fault_rise;
	logic [NUM_CH-1:0] fault_evt;
	logic [7:0] src_nxt;
	logic [31:0] rd_nxt;

	assign idx = idx_of(paddr);
	assign setup = ce && psel && !penable;
	// one wait-free access phase; ce low stalls the bus as well
	assign access = ce && psel && penable;
	assign wr = access && pwrite && pstrb[0] && is_mapped(idx);
	assign rd = access && !pwrite;

	assign pready = ce;
	assign prdata = prdata_r;
	assign pslverr = pslverr_r;

	// analog inputs cross into the clock domain
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			pg_meta_r <= '0;
			pg_s_r <= '0;
			flt_meta_r <= '0;
			flt_s_r <= '0;
			flt_d_r <= '0;
		end
		else if (ce)
		begin
			pg_meta_r <= power_good;
			pg_s_r <= pg_meta_r;
			flt_meta_r <= fault;
			flt_s_r <= flt_meta_r;
			flt_d_r <= flt_s_r;
		end
	end

	assign fault_rise = flt_s_r & ~flt_d_r;
	assign fault_evt = fault_rise & fie_r;

	// level select fields
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			for (int c = 0; c < NUM_CH; c++)
				level_r[c] <= LEVEL_RST;
		end
		else
		begin
			for (int c = 0; c < NUM_CH; c++)
				if (wr && idx == CH_LEVEL_IDX[c])
					level_r[c] <= pwdata[LEVEL_W-1:0];
		end
	end

	assign level_ch8 = level_r[0];
	assign level_ch9 = level_r[1];
	assign level_ch10 = level_r[2];

	// channel control bits; bits 6:3 are not stored
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			en_r <= CTRL_RST;
			discharge_en_r <= CTRL_RST;
			fie_r <= CTRL_RST;
		end
		else
		begin
			for (int c = 0; c < NUM_CH; c++)
				if (wr && idx == CH_CTRL_IDX[c])
				begin
					en_r[c] <= pwdata[BIT_ENABLE];
					discharge_en_r[c] <= pwdata[BIT_DISCHARGE];
					fie_r[c] <= pwdata[BIT_FAULT_IE];
				end
		end
	end

	assign regulator_on = en_r;
	// plain gate on both flops so discharge never overlaps enable
	assign discharge_on = discharge_en_r & ~en_r;

	// sticky fault status, write one to clear; new event wins
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			irq_status_r <= '0;
			irq_mask_r <= MASK_RST;
		end
		else if (ce)
		begin
			if (wr && idx == IDX_IRQ_MASK)
				irq_mask_r <= pwdata[NUM_CH-1:0];
			if (wr && idx == IDX_IRQ_STATUS)
				irq_status_r <= (irq_status_r & ~pwdata[NUM_CH-1:0])
					| fault_evt;
			else
				irq_status_r <= irq_status_r | fault_evt;
		end
	end

	assign irq = |(irq_status_r & irq_mask_r);

	// source address: lowest channel wins on simultaneous faults
	always_comb
	begin
		src_nxt = src_r;
		if (rd && idx == IDX_IRQ_SRC)
			src_nxt = SRC_IDLE;
		for (int c = int'(NUM_CH) - 1; c >= 0; c--)
			if (fault_evt[c])
				src_nxt = CH_LEVEL_IDX[c];
	end

	always_ff @(posedge clock)
	begin
		if (reset)
			src_r <= SRC_IDLE;
		else if (ce)
			src_r <= src_nxt;
	end

	// read mux; reserved bits and upper bytes come back zero
	always_comb
	begin
		rd_nxt = '0;
		for (int c = 0; c < NUM_CH; c++)
		begin
			if (idx == CH_LEVEL_IDX[c])
				rd_nxt[LEVEL_W-1:0] = level_r[c];
			if (idx == CH_CTRL_IDX[c])
			begin
				rd_nxt[BIT_ENABLE] = en_r[c];
				rd_nxt[BIT_DISCHARGE] = discharge_en_r[c];
				rd_nxt[BIT_FAULT_IE] = fie_r[c];
				rd_nxt[BIT_POWER_GOOD] = pg_s_r[c];
			end
		end
		if (idx == IDX_IRQ_SRC)
			rd_nxt[7:0] = src_r;
		if (idx == IDX_IRQ_STATUS)
			rd_nxt[NUM_CH-1:0] = irq_status_r;
		if (idx == IDX_IRQ_MASK)
			rd_nxt[NUM_CH-1:0] = irq_mask_r;
	end

	// read data captured in the setup cycle, held through access
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			prdata_r <= '0;
			pslverr_r <= 1'b0;
		end
		else if (setup)
		begin
			prdata_r <= pwrite ? 32'h0000_0000 : rd_nxt;
			pslverr_r <= !is_mapped(idx);
		end
	end

	// checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);

	a_discharge_exclusive: assert property (
		(discharge_on & regulator_on) == '0)
	else $error("discharge driven while regulator on");

	a_discharge_after_off: assert property (
		wr && idx == IDX_CH8_CTRL && !pwdata[BIT_ENABLE]
			&& pwdata[BIT_DISCHARGE]
		|=> discharge_on[0] && !regulator_on[0])
	else $error("discharge not driven after shutdown write");

	a_level_write: assert property (
		wr && idx == IDX_CH9_LEVEL
		|=> level_ch9 == $past(pwdata[LEVEL_W-1:0]))
	else $error("level select not updated");

	a_enable_write: assert property (
		wr && idx == IDX_CH10_CTRL
		|=> regulator_on[2] == $past(pwdata[BIT_ENABLE]))
	else $error("enable bit not updated");

	a_reserved_zero: assert property (
		access && !pwrite
		|-> prdata[31:8] == '0
			&& (idx != IDX_CH8_LEVEL || prdata[7:6] == 2'b00)
			&& (idx != IDX_CH8_CTRL || prdata[6:3] == 4'h0))
	else $error("reserved bits read nonzero");

	a_power_good_read: assert property (
		access && !pwrite && idx == IDX_CH8_CTRL && $past(setup)
		|-> prdata[BIT_POWER_GOOD] == $past(pg_s_r[0]))
	else $error("power-good bit mismatch");

	a_fault_masked: assert property (
		ce && fault_rise[1] && !fie_r[1] && !irq_status_r[1]
			&& src_r == SRC_IDLE && fault_evt == '0
		|=> !irq_status_r[1] && src_r == SRC_IDLE)
	else $error("disabled fault raised interrupt");

	a_fault_source: assert property (
		ce && fault_evt[0]
		|=> irq_status_r[0] && src_r == IDX_CH8_LEVEL)
	else $error("fault source not recorded");

	a_source_clear: assert property (
		rd && idx == IDX_IRQ_SRC && fault_evt == '0
		|=> src_r == SRC_IDLE)
	else $error("source address not cleared on read");

	// status, enable-discharge, level hold, freeze and error behaviour
	a_status_sticky: assert property (
		irq_status_r[0] && !(wr && idx == IDX_IRQ_STATUS)
		|=> irq_status_r[0])
	else $error("status bit lost without a clear");

	a_status_clear: assert property (
		wr && idx == IDX_IRQ_STATUS && pwdata[0] && !fault_evt[0]
		|=> !irq_status_r[0])
	else $error("status bit not cleared by write one");

	a_enable_blocks_discharge: assert property (
		wr && idx == IDX_CH9_CTRL && pwdata[BIT_ENABLE]
		|=> regulator_on[1] && !discharge_on[1])
	else $error("discharge left on after enable write");

	a_level_hold: assert property (
		!(wr && idx == IDX_CH8_LEVEL)
		|=> $stable(level_ch8))
	else $error("level select changed without a write");

	a_freeze_hold: assert property (
		!ce
		|=> $stable(en_r) && $stable(irq_status_r) && $stable(src_r))
	else $error("state moved while clock enable low");

	a_unmapped_error: assert property (
		setup && !is_mapped(idx)
		|=> pslverr && prdata == 32'h0000_0000)
	else $error("unmapped access without error");

endmodule : ldo_regs

// ===== dv/tb_ldo_regs.sv
/*
 * tb_ldo_regs: self-checking bench for the ldo register bank.
 * Assumes ldo_pkg, zero-wait apb slave while ce is high, 10 MHz clock.
 */
`timescale 1ns/1ps
module tb_ldo_regs
	import ldo_pkg::*;
;
	logic clock = 0;
	logic reset = 1;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [2:0] power_good = '0;
	logic [2:0] fault = '0;
	logic [2:0] regulator_on;
	logic [2:0] discharge_on;
	logic [5:0] level_ch8;
	logic [5:0] level_ch9;
	logic [5:0] level_ch10;
	logic irq;
	logic ce = 1;
	logic [3:0] pstrb = 4'hf;
	int errors = 0;
	int cmp_count = 0;
	int cycles = 0;
	logic [31:0] rd;
	logic er;

	ldo_regs u_ldo_regs (.clock(clock), .reset(reset), .ce(ce),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .power_good(power_good), .fault(fault),
		.regulator_on(regulator_on), .discharge_on(discharge_on),
		.level_ch8(level_ch8), .level_ch9(level_ch9),
		.level_ch10(level_ch10), .irq(irq));

	initial
	begin
		forever #50 clock = ~clock;
	end

	// hang guard, well above the few hundred cycles the tests need
	always @(posedge clock)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			errors++;
			give_verdict();
		end
	end

	task give_verdict();
		$display("errors %0d compares %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : give_verdict

	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e)
		begin
			errors++;
			$display("CHECK FAILED %s exp %h seen %h", n, e, s);
		end
	endtask : chk

	// one apb transfer; request held until pready is sampled high
	task apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= {24'h0, d};
		@(posedge clock);
		penable <= 1;
		@(posedge clock);
		while (pready !== 1'b1)
			@(posedge clock);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		// idle edge: no double drive in one step, outputs settled
		@(posedge clock);
	endtask : apb

	task t_reset();
		for (int i = 0; i < 3; i++)
		begin
			apb(0, CH_LEVEL_IDX[i], 0);
			chk("level rst", rd, 0);
			apb(0, CH_CTRL_IDX[i], 0);
			chk("ctrl rst", rd, 0);
		end
		apb(0, IDX_IRQ_SRC, 0);
		chk("src rst", rd, 32'h000000ff);
		chk("irq rst", irq, 0);
		$display("reset test done");
	endtask : t_reset

	task t_level();
		logic [5:0] lv;
		for (int i = 0; i < 3; i++)
		begin
			apb(1, CH_LEVEL_IDX[i], 8'hff - 8'(i));
			apb(0, CH_LEVEL_IDX[i], 0);
			chk("level rd", rd, 32'(6'h3f - 6'(i)));
			lv = i == 0 ? level_ch8 : i == 1 ? level_ch9 : level_ch10;
			chk("level pin", lv, 6'h3f - 6'(i));
		end
		$display("level test done");
	endtask : t_level

	task t_ctrl();
		for (int i = 0; i < 3; i++)
		begin
			apb(1, CH_CTRL_IDX[i], 8'hff);
			apb(0, CH_CTRL_IDX[i], 0);
			chk("ctrl on", rd, 32'h86);
			chk("on pin", regulator_on[i], 1);
			chk("discharge when on", discharge_on[i], 0);
			apb(1, CH_CTRL_IDX[i], 8'h7c);
			apb(0, CH_CTRL_IDX[i], 0);
			chk("ctrl off", rd, 32'h04);
			chk("off pin", regulator_on[i], 0);
			chk("discharge when off", discharge_on[i], 1);
			apb(1, CH_CTRL_IDX[i], 8'h00);
			chk("discharge cleared", discharge_on[i], 0);
		end
		power_good <= 3'b101;
		repeat (3) @(posedge clock);
		apb(0, IDX_CH10_CTRL, 0);
		chk("pg high", rd, 32'h01);
		apb(0, IDX_CH8_CTRL, 0);
		chk("pg high ch8", rd, 32'h01);
		apb(1, IDX_CH9_CTRL, 8'h01);
		apb(0, IDX_CH9_CTRL, 0);
		chk("pg low ro", rd, 32'h00);
		apb(0, 8'h6a, 0);
		chk("unmapped err", er, 1);
		chk("unmapped data", rd, 0);
		$display("control test done");
	endtask : t_ctrl

	task t_fault();
		apb(1, IDX_IRQ_MASK, 8'h01);
		apb(1, IDX_CH8_CTRL, 8'h02);
		apb(1, IDX_CH9_CTRL, 8'h00);
		apb(1, IDX_CH10_CTRL, 8'h02);
		apb(0, IDX_IRQ_MASK, 0);
		chk("mask rd", rd, 32'h01);
		// ch9 alone, its fault interrupt disabled
		fault <= 3'b010;
		repeat (5) @(posedge clock);
		apb(0, IDX_IRQ_STATUS, 0);
		chk("disabled fault", rd, 32'h00);
		apb(0, IDX_IRQ_SRC, 0);
		chk("src untouched", rd, 32'hff);
		fault <= 3'b110;
		repeat (5) @(posedge clock);
		chk("masked irq", irq, 0);
		apb(0, IDX_IRQ_STATUS, 0);
		chk("status ch10 only", rd, 32'h04);
		apb(0, IDX_IRQ_SRC, 0);
		chk("src ch10", rd, 32'h80);
		fault <= 3'b111;
		repeat (5) @(posedge clock);
		chk("irq up", irq, 1);
		apb(0, IDX_IRQ_SRC, 0);
		chk("src addr", rd, 32'h68);
		apb(0, IDX_IRQ_SRC, 0);
		chk("src after read", rd, 32'hff);
		apb(1, IDX_IRQ_STATUS, 8'h07);
		chk("irq cleared", irq, 0);
		apb(0, IDX_IRQ_STATUS, 0);
		chk("status cleared", rd, 32'h00);
		fault <= 3'b000;
		$display("fault test done");
	endtask : t_fault

	task t_freeze();
		apb(1, IDX_CH8_LEVEL, 8'h15);
		ce <= 0;
		fault <= 3'b001;
		repeat (6) @(posedge clock);
		chk("ready low", pready, 0);
		chk("frozen irq", irq, 0);
		chk("frozen level", level_ch8, 6'h15);
		ce <= 1;
		repeat (5) @(posedge clock);
		chk("irq after ce", irq, 1);
		apb(1, IDX_IRQ_STATUS, 8'h01);
		chk("irq cleared again", irq, 0);
		fault <= 3'b000;
		$display("freeze test done");
	endtask : t_freeze

	task t_rerst();
		apb(1, IDX_CH9_CTRL, 8'h80);
		chk("on before rst", regulator_on, 3'b010);
		reset <= 1;
		repeat (2) @(posedge clock);
		reset <= 0;
		@(posedge clock);
		chk("on after rst", regulator_on, 0);
		apb(0, IDX_CH8_LEVEL, 0);
		chk("level after rst", rd, 0);
		apb(0, IDX_IRQ_SRC, 0);
		chk("src after rst", rd, 32'hff);
		pstrb <= 4'he;
		apb(1, IDX_CH8_LEVEL, 8'h2a);
		pstrb <= 4'hf;
		apb(0, IDX_CH8_LEVEL, 0);
		chk("strobe off", rd, 0);
		$display("reset again test done");
	endtask : t_rerst

	initial
	begin
		repeat (3) @(posedge clock);
		reset <= 0;
		@(posedge clock);
		t_reset();
		t_level();
		t_ctrl();
		t_fault();
		t_freeze();
		t_rerst();
		give_verdict();
	end
endmodule : tb_ldo_regs
